/* bench/tb_top.sv */
/*
 * Self-checking bench for the reset source recorder: drives the reset
 * sources and the strobe register port, and predicts the cause register.
 * Assumes rsr_pkg is compiled first; long counts are shortened by parameter.
 */
`timescale 1ns/1ps
module tb_top;

    // ****************************************
    // Signals and bench state
    // ****************************************
    logic       i_sys_clk;
    logic       i_sys_rst;
    logic       i_reset_pin_n;
    logic       i_watchdog_reset_request;
    logic       i_clock_loss_monitor_stop;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic [7:0] i_wmask;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       o_sys_reset;
    logic       o_main_osc_en;
    logic       o_cpu_on_internal_osc;
    logic       o_irq;
    int         miscompares  = 0;
    int         total_checks = 0;
    int         cycles       = 0;
    logic [7:0] exp_cause;
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] m;
    logic [31:0] r;

    // Short hold and wait keep each reset round trip near a dozen cycles
    rsr_top #(.HOLD_CYC(3), .STAB_CYC(5)) i_rsr_top (
        .i_sys_clk                 (i_sys_clk),
        .i_sys_rst                 (i_sys_rst),
        .i_reset_pin_n             (i_reset_pin_n),
        .i_watchdog_reset_request  (i_watchdog_reset_request),
        .i_clock_loss_monitor_stop (i_clock_loss_monitor_stop),
        .i_addr                    (i_addr),
        .i_wdata                   (i_wdata),
        .i_wmask                   (i_wmask),
        .i_wr                      (i_wr),
        .i_rd                      (i_rd),
        .o_rdata                   (o_rdata),
        .o_sys_reset               (o_sys_reset),
        .o_main_osc_en             (o_main_osc_en),
        .o_cpu_on_internal_osc     (o_cpu_on_internal_osc),
        .o_irq                     (o_irq)
    );

    // 20 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [7:0] msk);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= dat;
        i_wmask <= msk;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] val);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 val = o_rdata;
    endtask

    task automatic clear_cause(input logic [7:0] dat, input logic [7:0] msk);
        wr(rsr_pkg::ADDR_UNLOCK, rsr_pkg::UNLOCK_KEY, 8'hFF);
        wr(rsr_pkg::ADDR_CAUSE, dat, msk);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        #1; // Callers may arrive on an edge; let its updates settle first
        while (o_sys_reset !== 1'b0 && n < 100) begin
            @(posedge i_sys_clk);
            #1 n = n + 1;
        end
        check("reset release", 8'h00, {7'h00, o_sys_reset});
    endtask

    // One-cycle request; wd selects watchdog, else clock loss
    task automatic pulse(input bit wd);
        @(posedge i_sys_clk);
        if (wd) begin
            i_watchdog_reset_request <= 1'b1;
        end else begin
            i_clock_loss_monitor_stop <= 1'b1;
        end
        @(posedge i_sys_clk);
        i_watchdog_reset_request  <= 1'b0;
        i_clock_loss_monitor_stop <= 1'b0;
        #1;
    endtask

    function automatic logic [7:0] flag_of(input bit wd);
        return wd ? (8'h01 << rsr_pkg::BIT_WDT) : (8'h01 << rsr_pkg::BIT_LOSS);
    endfunction

    // Internal reset in RUN, then cause compare after release
    task automatic fire(input bit wd);
        pulse(wd);
        exp_cause = exp_cause | flag_of(wd);
        check("reset on event", 8'h01, {7'h00, o_sys_reset});
        check("osc in hold", 8'h00, {7'h00, o_main_osc_en});
        wait_run();
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("cause", exp_cause, q);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        i_sys_rst = 1'b1;
        i_reset_pin_n = 1'b1;
        i_watchdog_reset_request = 1'b0;
        i_clock_loss_monitor_stop = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wmask = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        exp_cause = rsr_pkg::CAUSE_RST;
        void'($urandom(59550));
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        wait_run();
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("cause after power-on", 8'h00, q);
        rd(rsr_pkg::ADDR_IRQ_MK, q);
        check("irq mask", rsr_pkg::IRQ_MASK_RST, q);
        rd(8'h20, q);
        check("unmapped read", 8'h00, q);
        // Interrupt: unmasked events raise the line, a status read drops it
        rd(rsr_pkg::ADDR_IRQ_ST, q);
        wr(rsr_pkg::ADDR_IRQ_MK, 8'h11, 8'hFF);
        fire(1'b1);
        check("irq raised", 8'h01, {7'h00, o_irq});
        fire(1'b0);
        rd(rsr_pkg::ADDR_IRQ_ST, q);
        check("irq status", 8'h11, q);
        check("irq cleared", 8'h00, {7'h00, o_irq});
        wr(rsr_pkg::ADDR_IRQ_MK, 8'h00, 8'hFF);
        fire(1'b1);
        check("irq masked", 8'h00, {7'h00, o_irq});
        // Writes without unlock are dropped; ones never set a flag
        wr(rsr_pkg::ADDR_CAUSE, 8'h00, 8'hFF);
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("unprotected write", exp_cause, q);
        clear_cause(8'h00, 8'h10);
        exp_cause = 8'h01;
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("single bit clear", exp_cause, q);
        clear_cause(8'hFF, 8'hFF);
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("write of ones", exp_cause, q);
        // Clearing write in the same cycle as a watchdog event
        wr(rsr_pkg::ADDR_UNLOCK, rsr_pkg::UNLOCK_KEY, 8'hFF);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= rsr_pkg::ADDR_CAUSE;
        i_wdata <= 8'h00;
        i_wmask <= 8'hFF;
        i_watchdog_reset_request <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_watchdog_reset_request <= 1'b0;
        exp_cause = 8'h10;
        wait_run();
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("event beats clear", exp_cause, q);
        // Random mix of events, protected and unprotected writes
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            d = r[15:8];
            m = r[23:16];
            if (r[1:0] == 2'd0) begin
                fire(1'b1);
            end else if (r[1:0] == 2'd1) begin
                fire(1'b0);
            end else if (r[4]) begin
                clear_cause(d, m);
                exp_cause = exp_cause & ~(m & ~d);
            end else begin
                wr(rsr_pkg::ADDR_CAUSE, d, m);
            end
            rd(rsr_pkg::ADDR_CAUSE, q);
            check("random cause", exp_cause, q);
        end
        // Watchdog during the oscillator wait starts on the internal clock
        pulse(1'b0);
        exp_cause = exp_cause | flag_of(1'b0);
        for (int n = 0; n < 50 && !(o_main_osc_en === 1'b1 && o_sys_reset === 1'b1); n++) begin
            @(posedge i_sys_clk);
            #1;
        end
        pulse(1'b1);
        exp_cause = exp_cause | flag_of(1'b1);
        check("emergency", 8'h01, {7'h00, o_cpu_on_internal_osc});
        check("emergency osc", 8'h00, {7'h00, o_main_osc_en});
        check("emergency run", 8'h00, {7'h00, o_sys_reset});
        rd(rsr_pkg::ADDR_STATUS, q);
        check("emergency status", {3'h0, 1'b1, rsr_pkg::ST_RUN}, q);
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("cause emergency", exp_cause, q);
        // Both sources and the emergency bit accumulated since the last status read
        rd(rsr_pkg::ADDR_IRQ_ST, q);
        check("irq status emergency", 8'h15, q);
        // Pin reset holds the device, ignores requests, clears the flags
        @(posedge i_sys_clk);
        i_reset_pin_n <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        #1 check("pin holds reset", 8'h01, {7'h00, o_sys_reset});
        pulse(1'b1);
        rd(rsr_pkg::ADDR_CAUSE, q);
        check("pin clears cause", 8'h00, q);
        check("pin ends emergency", 8'h00, {7'h00, o_cpu_on_internal_osc});
        @(posedge i_sys_clk);
        i_reset_pin_n <= 1'b1;
        wait_run();
        check("osc after pin", 8'h01, {7'h00, o_main_osc_en});
        give_verdict();
    end

endmodule

/* verilog/rsr_pin_sync.sv */
/*
 * Three-stage synchroniser with agreement filter for the reset pin.
 * Assumes an asynchronous, slowly changing level on i_pin.
 */
`timescale 1ns/1ps
module rsr_pin_sync (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    // Pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    logic lvl_next;

    // Level moves only when stages two and three agree; stage one feeds stage two alone
    always_comb begin
        lvl_next = lvl_reg;
        if (s2_reg == s3_reg) begin
            lvl_next = s3_reg;
        end
    end

    // Reset as released pin so a power-up does not look like a pin reset
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s1_reg  <= 1'b1;
            s2_reg  <= 1'b1;
            s3_reg  <= 1'b1;
            lvl_reg <= 1'b1;
        end else begin
            s1_reg  <= i_pin;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign o_level = lvl_reg;

endmodule

/* verilog/rsr_pkg.sv */
/*
 * Constants shared by the reset source recorder: register offsets,
 * flag positions, reset values and timing figures.
 * Assumes a 20 MHz system clock and a plain strobe register port.
 */
// Contract
// - The block accepts the reset pin, the watchdog reset request and the clock loss monitor.
// - A low reset pin clears the whole cause register to zero.
// - A watchdog reset sets its flag and a clock monitor reset sets its own flag.
// - Setting one flag leaves every other flag as it was, so causes accumulate.
// - Each flag reads 1 once its source fired since the last clear and 0 otherwise.
// - A reset event in the cycle of a clearing write sets the flag and drops the clear; the code still applies the clear to the other flags.
// - A cause register write counts only right after the unlock write, others are ignored.
// - The cause register is written as a whole byte or as single bits.
// - A watchdog overflow during the oscillator wait starts the CPU on the internal clock.
// - A low reset pin holds the device in reset and a rising edge releases it.
// - A watchdog reset holds reset for a fixed delay with the main oscillator stopped.
package rsr_pkg;

    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam logic [7:0] ADDR_CAUSE  = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ********************************
    // Fields and reset values
    // ********************************
    localparam int         BIT_LOSS      = 0;
    localparam int         BIT_WDT       = 4;
    localparam int         BIT_EMERG     = 2;
    localparam logic [7:0] CAUSE_RST     = 8'h00;
    localparam logic [7:0] UNLOCK_KEY    = 8'hA5;
    localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_HOLD_NS   = 800;
    localparam int OSC_STAB_NS   = 409600;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_STAB_CYC  = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_PIN  = 4'h1,
        ST_HOLD = 4'h2,
        ST_STAB = 4'h4,
        ST_RUN  = 4'h8
    } rsr_state_t;

endpackage

/* verilog/rsr_top.sv */
/*
 * Reset source recorder: merges the reset pin, watchdog and clock loss
 * monitor into one system reset, sequences the oscillator wait and the
 * emergency internal-clock start, and keeps a sticky cause register.
 * Assumes i_sys_rst is a power-on reset and the two request inputs are
 * synchronous one-cycle or level signals on i_sys_clk.
 */
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rsr_top #(
    parameter int HOLD_CYC = rsr_pkg::RST_HOLD_CYC,
    parameter int STAB_CYC = rsr_pkg::OSC_STAB_CYC
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_sys_rst,
    // Reset sources
    input  wire logic       i_reset_pin_n,
    input  wire logic       i_watchdog_reset_request,
    input  wire logic       i_clock_loss_monitor_stop,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_wmask,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // System outputs
    output logic            o_sys_reset,
    output logic            o_main_osc_en,
    output logic            o_cpu_on_internal_osc,
    output logic            o_irq
);

    // ********************************
    // Elaboration checks
    // ********************************
    // The 16-bit sequencer counter cannot serve longer waits
    if (HOLD_CYC < 1 || HOLD_CYC > 65535 || STAB_CYC < 1 || STAB_CYC > 65535) begin
        $error("rsr_top: counts must lie in 1..65535");
    end

    // ********************************
    // Pin synchroniser
    // ********************************
    logic pin_level;
    logic pin_low;

    rsr_pin_sync u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_reset_pin_n),
        .o_level   (pin_level)
    );

    assign pin_low = ~pin_level;

    // ********************************
    // Source decode
    // ********************************
    logic wdt_ev;
    logic loss_ev;

    // Pin reset dominates; internal sources only count while the pin is high
    assign wdt_ev  = i_watchdog_reset_request & ~pin_low;
    assign loss_ev = i_clock_loss_monitor_stop & ~pin_low;

    // ********************************
    // Reset sequencer
    // ********************************
    rsr_pkg::rsr_state_t state_reg;
    rsr_pkg::rsr_state_t state_next;
    logic [15:0]         cnt_reg;
    logic [15:0]         cnt_next;
    logic                emerg_reg;
    logic                emerg_next;
    logic                emerg_hit;

    // Next state: pin or hold, then oscillator wait, then run
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        emerg_next = emerg_reg;
        emerg_hit  = 1'b0;
        if (pin_low) begin
            state_next = rsr_pkg::ST_PIN;
            emerg_next = 1'b0;
            cnt_next   = 16'h0000;
        end else begin
            case (state_reg)
                rsr_pkg::ST_PIN: begin
                    // Release lands on a clock edge, never on the raw pin edge
                    state_next = rsr_pkg::ST_STAB;
                    cnt_next   = 16'h0000;
                end
                rsr_pkg::ST_HOLD: begin
                    if (cnt_reg >= 16'(HOLD_CYC - 1)) begin
                        state_next = rsr_pkg::ST_STAB;
                        cnt_next   = 16'h0000;
                    end else begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                rsr_pkg::ST_STAB: begin
                    if (wdt_ev) begin
                        // Oscillator judged faulty: run on the internal clock at once
                        state_next = rsr_pkg::ST_RUN;
                        emerg_next = 1'b1;
                        emerg_hit  = 1'b1;
                    end else if (loss_ev) begin
                        state_next = rsr_pkg::ST_HOLD;
                        cnt_next   = 16'h0000;
                    end else if (cnt_reg >= 16'(STAB_CYC - 1)) begin
                        state_next = rsr_pkg::ST_RUN;
                    end else begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                rsr_pkg::ST_RUN: begin
                    if (wdt_ev || loss_ev) begin
                        state_next = rsr_pkg::ST_HOLD;
                        cnt_next   = 16'h0000;
                    end
                end
                default: begin
                    state_next = rsr_pkg::ST_PIN;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_reg <= rsr_pkg::ST_PIN;
            cnt_reg   <= 16'h0000;
            emerg_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            emerg_reg <= emerg_next;
        end
    end

    // One merged reset; oscillator is off in pin and hold states and in emergency run
    assign o_sys_reset           = (state_reg != rsr_pkg::ST_RUN);
    assign o_main_osc_en         = (state_reg == rsr_pkg::ST_STAB) ||
                                   (state_reg == rsr_pkg::ST_RUN && !emerg_reg);
    assign o_cpu_on_internal_osc = emerg_reg;

    // ********************************
    // Cause register and unlock
    // ********************************
    logic [7:0] cause_reg;
    logic [7:0] cause_next;
    logic       armed_reg;
    logic       armed_next;
    logic       cause_wr;
    logic [7:0] clr_bits;
    logic [7:0] set_bits;

    // A cause write counts only as the write right after the unlock key
    assign cause_wr = i_wr && armed_reg && (i_addr == rsr_pkg::ADDR_CAUSE);

    // Cleared bits: masked lanes written with zero; ones are ignored
    assign clr_bits = (cause_wr) ? (i_wmask & ~i_wdata) : 8'h00;

    always_comb begin
        set_bits = 8'h00;
        set_bits[rsr_pkg::BIT_WDT] = wdt_ev;
        set_bits[rsr_pkg::BIT_LOSS] = loss_ev;
    end

    // Pin clears all, else clear then set so a coincident event wins
    always_comb begin
        armed_next = armed_reg;
        if (i_wr) begin
            armed_next = (i_addr == rsr_pkg::ADDR_UNLOCK) && (i_wdata == rsr_pkg::UNLOCK_KEY);
        end
        if (pin_low) begin
            cause_next = rsr_pkg::CAUSE_RST;
        end else begin
            cause_next = (cause_reg & ~clr_bits) | set_bits;
        end
    end

    // Cause flags survive internal resets; only power-on, the pin and unlocked cause writes clear them
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cause_reg <= rsr_pkg::CAUSE_RST;
            armed_reg <= 1'b0;
        end else begin
            cause_reg <= cause_next;
            armed_reg <= armed_next;
        end
    end

    // ********************************
    // Interrupt status and mask
    // ********************************
    logic [7:0] ist_reg;
    logic [7:0] ist_next;
    logic [7:0] imk_reg;
    logic [7:0] imk_next;
    logic [7:0] ev_bits;

    always_comb begin
        ev_bits = set_bits;
        ev_bits[rsr_pkg::BIT_EMERG] = emerg_hit;
    end

    // Read clears, but an event in the same cycle stays set
    always_comb begin
        ist_next = ist_reg;
        imk_next = imk_reg;
        if (i_rd && i_addr == rsr_pkg::ADDR_IRQ_ST) begin
            ist_next = 8'h00;
        end
        ist_next = ist_next | ev_bits;
        if (i_wr && i_addr == rsr_pkg::ADDR_IRQ_MK) begin
            imk_next = i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ist_reg <= 8'h00;
            imk_reg <= rsr_pkg::IRQ_MASK_RST;
        end else begin
            ist_reg <= ist_next;
            imk_reg <= imk_next;
        end
    end

    assign o_irq = |(ist_reg & imk_reg);

    // ********************************
    // Read port
    // ********************************
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Data of a read stands the next cycle only; unmapped reads give zero
    always_comb begin
        rdata_next = 8'h00;
        if (!i_rd) begin
            rdata_next = 8'h00;
        end else if (i_addr == rsr_pkg::ADDR_CAUSE) begin
            rdata_next = cause_reg;
        end else if (i_addr == rsr_pkg::ADDR_IRQ_ST) begin
            rdata_next = ist_reg;
        end else if (i_addr == rsr_pkg::ADDR_IRQ_MK) begin
            rdata_next = imk_reg;
        end else if (i_addr == rsr_pkg::ADDR_STATUS) begin
            rdata_next = {3'h0, emerg_reg, state_reg};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    // ********************************
    // Checks
    // ********************************
    chk_pin_clears_flags: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        pin_low |=> cause_reg == 8'h00)
        else $error("pin reset did not clear cause flags");

    chk_wdt_sets_flag: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        wdt_ev |=> cause_reg[rsr_pkg::BIT_WDT])
        else $error("watchdog flag not set");

    chk_loss_sets_flag: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        loss_ev |=> cause_reg[rsr_pkg::BIT_LOSS])
        else $error("clock monitor flag not set");

    chk_other_flag_kept: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (wdt_ev && !loss_ev && !cause_wr)
        |=> cause_reg[rsr_pkg::BIT_LOSS] == $past(cause_reg[rsr_pkg::BIT_LOSS]))
        else $error("unrelated flag changed");

    chk_unlocked_write: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_wr && !armed_reg && !pin_low && !wdt_ev && !loss_ev) |=> $stable(cause_reg))
        else $error("unprotected write changed flags");

    chk_bit_write_lane: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (cause_wr && !pin_low && !wdt_ev && !loss_ev)
        |=> ((cause_reg ^ $past(cause_reg)) & ~$past(i_wmask)) == 8'h00)
        else $error("write touched an unselected bit");

    chk_emerg_entry: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (state_reg == rsr_pkg::ST_STAB && wdt_ev)
        |=> o_cpu_on_internal_osc && !o_sys_reset && !o_main_osc_en)
        else $error("emergency start missed");

    chk_hold_osc_off: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (state_reg == rsr_pkg::ST_HOLD) |-> (o_sys_reset && !o_main_osc_en))
        else $error("oscillator running during reset hold");

    chk_pin_holds: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        pin_low |=> (state_reg == rsr_pkg::ST_PIN) && o_sys_reset)
        else $error("pin low did not hold reset");

    chk_hold_release: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (state_reg == rsr_pkg::ST_HOLD && cnt_reg >= 16'(HOLD_CYC - 1) && !pin_low)
        |=> (state_reg == rsr_pkg::ST_STAB) && o_main_osc_en)
        else $error("reset hold did not end on time");

    chk_stab_release: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (state_reg == rsr_pkg::ST_STAB && cnt_reg >= 16'(STAB_CYC - 1)
         && !wdt_ev && !loss_ev && !pin_low)
        |=> !o_sys_reset)
        else $error("reset not released after oscillator wait");

    chk_run_to_hold: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (state_reg == rsr_pkg::ST_RUN && (wdt_ev || loss_ev))
        |=> (state_reg == rsr_pkg::ST_HOLD) && o_sys_reset && !o_main_osc_en)
        else $error("internal reset request not taken");

    chk_emerg_from_wait: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(emerg_reg) |-> $past(state_reg) == rsr_pkg::ST_STAB)
        else $error("emergency mode entered outside oscillator wait");

    chk_pin_ends_emerg: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        pin_low |=> !o_cpu_on_internal_osc)
        else $error("pin reset left emergency mode on");

    chk_rdata_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside the cycle after a read");

endmodule
